// File: src/gloic_consts.svh
// Register offsets, reset values and sizes of the GPIO line controller
`ifndef GLOIC_CONSTS_SVH
`define GLOIC_CONSTS_SVH
`define GLOIC_NLINES 32
`define GLOIC_AW 8
`define GLOIC_OFF_OWN_SET 8'h00
`define GLOIC_OFF_OWN_CLR 8'h04
`define GLOIC_OFF_OWN_STS 8'h08
`define GLOIC_OFF_OE_SET 8'h10
`define GLOIC_OFF_OE_CLR 8'h14
`define GLOIC_OFF_OE_STS 8'h18
`define GLOIC_OFF_DG_SET 8'h20
`define GLOIC_OFF_DG_CLR 8'h24
`define GLOIC_OFF_DG_STS 8'h28
`define GLOIC_OFF_LV_SET 8'h30
`define GLOIC_OFF_LV_CLR 8'h34
`define GLOIC_OFF_LV_STS 8'h38
`define GLOIC_OFF_PIN_STS 8'h3c
`define GLOIC_OFF_IM_SET 8'h40
`define GLOIC_OFF_IM_CLR 8'h44
`define GLOIC_OFF_IM_STS 8'h48
`define GLOIC_OFF_EV_STS 8'h4c
`define GLOIC_OFF_OD_SET 8'h50
`define GLOIC_OFF_OD_CLR 8'h54
`define GLOIC_OFF_OD_STS 8'h58
`define GLOIC_OFF_PS_A 8'h70
`define GLOIC_OFF_PS_B 8'h74
`define GLOIC_OFF_PS_STS 8'h78
`define GLOIC_OFF_SW_SET 8'ha0
`define GLOIC_OFF_SW_CLR 8'ha4
`define GLOIC_OFF_SW_STS 8'ha8
`define GLOIC_RST_ZERO 32'h0000_0000
`define GLOIC_RST_OWNER 32'hffff_ffff
`define GLOIC_RD_UNMAPPED 32'h0000_0000
`endif

// File: src/gloic_pkg.sv
// Types shared by the GPIO line controller
package gloic_pkg;
  typedef logic [31:0] gloic_word_t;
  typedef enum logic [1:0] {
    GLOIC_BUS_IDLE = 2'b01,
    GLOIC_BUS_ACK = 2'b10
  } gloic_bus_st_t;
endpackage

// File: src/gloic_top.sv
// GPIO line controller: 32 lines, Avalon-MM register slave
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "gloic_consts.svh"

module gloic_top
  import gloic_pkg::*;
(
  // Clock, reset, controller clock gate
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [`GLOIC_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pads
  input wire logic [`GLOIC_NLINES-1:0] pad_in,
  output logic [`GLOIC_NLINES-1:0] pad_out,
  output logic [`GLOIC_NLINES-1:0] pad_oe,
  // Peripheral A and B functions
  input wire logic [`GLOIC_NLINES-1:0] pa_out,
  input wire logic [`GLOIC_NLINES-1:0] pa_oe,
  input wire logic [`GLOIC_NLINES-1:0] pb_out,
  input wire logic [`GLOIC_NLINES-1:0] pb_oe,
  output logic [`GLOIC_NLINES-1:0] periph_in,
  // Interrupt
  output logic irq
);

  // Bus state and software-visible registers
  gloic_bus_st_t bus_q;
  gloic_bus_st_t bus_d;
  gloic_word_t own_q;
  gloic_word_t oe_q;
  gloic_word_t dg_q;
  gloic_word_t lv_q;
  gloic_word_t im_q;
  gloic_word_t ev_q;
  gloic_word_t od_q;
  gloic_word_t ps_q;
  gloic_word_t sw_q;

  // Next values of the software-visible registers
  gloic_word_t own_d;
  gloic_word_t oe_d;
  gloic_word_t dg_d;
  gloic_word_t lv_d;
  gloic_word_t im_d;
  gloic_word_t ev_d;
  gloic_word_t od_d;
  gloic_word_t ps_d;
  gloic_word_t sw_d;

  // Input sampling and read data
  gloic_word_t sync1_q;
  gloic_word_t sync2_q;
  gloic_word_t dly_q;
  gloic_word_t pin_q;
  gloic_word_t rdata_q;

  // Combinational datapath
  gloic_word_t in_val;
  gloic_word_t change;
  gloic_word_t wmask;
  gloic_word_t wdat;
  gloic_word_t rd_mux;

  // Bus handshake
  logic req;
  logic take;
  logic wr_fire;
  logic rd_take;

  // Set bits win over clear bits written in the same access
  function automatic gloic_word_t set_clr(input gloic_word_t q,
                                          input logic do_set,
                                          input logic do_clr,
                                          input gloic_word_t bits);
    gloic_word_t r;
    r = q;
    if (do_clr) begin
      r = r & ~bits;
    end
    if (do_set) begin
      r = r | bits;
    end
    return r;
  endfunction

  // Bus handshake: every access is held one cycle by waitrequest
  assign req = avs_read | avs_write;
  assign take = req & (bus_q == GLOIC_BUS_IDLE);
  assign wr_fire = avs_write & (bus_q == GLOIC_BUS_ACK);
  assign rd_take = avs_read & take;
  assign avs_waitrequest = req & (bus_q == GLOIC_BUS_IDLE);
  assign avs_readdata = rdata_q;

  // Answer state lasts one cycle, so a request held into it is not taken twice
  always_comb begin
    bus_d = GLOIC_BUS_IDLE;
    case (bus_q)
      GLOIC_BUS_IDLE: begin
        if (take) begin
          bus_d = GLOIC_BUS_ACK;
        end
      end
      GLOIC_BUS_ACK: begin
        bus_d = GLOIC_BUS_IDLE;
      end
      default: begin
        bus_d = GLOIC_BUS_IDLE;
      end
    endcase
  end

  // Byte lanes gate write data; reads ignore them
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdat = avs_writedata & wmask;

  // Write decode
  wire w_own_s = wr_fire & (avs_address == `GLOIC_OFF_OWN_SET);
  wire w_own_c = wr_fire & (avs_address == `GLOIC_OFF_OWN_CLR);
  wire w_oe_s = wr_fire & (avs_address == `GLOIC_OFF_OE_SET);
  wire w_oe_c = wr_fire & (avs_address == `GLOIC_OFF_OE_CLR);
  wire w_dg_s = wr_fire & (avs_address == `GLOIC_OFF_DG_SET);
  wire w_dg_c = wr_fire & (avs_address == `GLOIC_OFF_DG_CLR);
  wire w_lv_s = wr_fire & (avs_address == `GLOIC_OFF_LV_SET);
  wire w_lv_c = wr_fire & (avs_address == `GLOIC_OFF_LV_CLR);
  wire w_lv_w = wr_fire & (avs_address == `GLOIC_OFF_LV_STS);
  wire w_im_s = wr_fire & (avs_address == `GLOIC_OFF_IM_SET);
  wire w_im_c = wr_fire & (avs_address == `GLOIC_OFF_IM_CLR);
  wire w_od_s = wr_fire & (avs_address == `GLOIC_OFF_OD_SET);
  wire w_od_c = wr_fire & (avs_address == `GLOIC_OFF_OD_CLR);
  wire w_ps_a = wr_fire & (avs_address == `GLOIC_OFF_PS_A);
  wire w_ps_b = wr_fire & (avs_address == `GLOIC_OFF_PS_B);
  wire w_sw_s = wr_fire & (avs_address == `GLOIC_OFF_SW_SET);
  wire w_sw_c = wr_fire & (avs_address == `GLOIC_OFF_SW_CLR);

  // Read decode
  wire r_own = avs_address == `GLOIC_OFF_OWN_STS;
  wire r_oe = avs_address == `GLOIC_OFF_OE_STS;
  wire r_dg = avs_address == `GLOIC_OFF_DG_STS;
  wire r_lv = avs_address == `GLOIC_OFF_LV_STS;
  wire r_pin = avs_address == `GLOIC_OFF_PIN_STS;
  wire r_im = avs_address == `GLOIC_OFF_IM_STS;
  wire r_ev = avs_address == `GLOIC_OFF_EV_STS;
  wire r_od = avs_address == `GLOIC_OFF_OD_STS;
  wire r_ps = avs_address == `GLOIC_OFF_PS_STS;
  wire r_sw = avs_address == `GLOIC_OFF_SW_STS;
  // Anything else reads as zero
  wire r_any = r_own | r_oe | r_dg | r_lv | r_pin | r_im | r_ev | r_od | r_ps | r_sw;

  assign rd_mux = ({32{r_own}} & own_q)
                | ({32{r_oe}} & oe_q)
                | ({32{r_dg}} & dg_q)
                | ({32{r_lv}} & lv_q)
                | ({32{r_pin}} & pin_q)
                | ({32{r_im}} & im_q)
                | ({32{r_ev}} & ev_q)
                | ({32{r_od}} & od_q)
                | ({32{r_ps}} & ps_q)
                | ({32{r_sw}} & sw_q)
                | ({32{~r_any}} & `GLOIC_RD_UNMAPPED);

  // Configuration updates; none depend on the line's current owner
  assign own_d = set_clr(own_q, w_own_s, w_own_c, wdat);
  assign oe_d = set_clr(oe_q, w_oe_s, w_oe_c, wdat);
  assign dg_d = set_clr(dg_q, w_dg_s, w_dg_c, wdat);
  assign im_d = set_clr(im_q, w_im_s, w_im_c, wdat);
  assign od_d = set_clr(od_q, w_od_s, w_od_c, wdat);
  assign ps_d = set_clr(ps_q, w_ps_b, w_ps_a, wdat);
  assign sw_d = set_clr(sw_q, w_sw_s, w_sw_c, wdat);

  // Direct write replaces only the bits opened by the mask
  assign lv_d = w_lv_w ? ((lv_q & ~(sw_q & wmask)) | (avs_writedata & sw_q & wmask))
              : set_clr(lv_q, w_lv_s, w_lv_c, wdat);

  // Input path: glitch filter is a one-sample delay, as inputs are already sampled
  // A level held for one clock always passes; nothing shorter reaches this logic
  assign in_val = (dg_q & dly_q) | (~dg_q & sync2_q);
  // Two successive samples differ; a stopped controller clock raises no event
  assign change = {32{clk_en}} & (in_val ^ pin_q);
  // Read clears everything; a change in the same cycle still lands
  wire ev_rd_clr = rd_take & r_ev;
  assign ev_d = (ev_rd_clr ? `GLOIC_RST_ZERO : ev_q) | change;

  // Level interrupt: stays up until a status read takes the events away or the mask bit is cleared
  assign irq = |(ev_q & im_q);
  // Peripherals see the raw pin, without filter or synchroniser
  assign periph_in = pad_in;

  // Pad drive per line
  genvar gi;
  generate
    for (gi = 0; gi < `GLOIC_NLINES; gi = gi + 1) begin : g_line
      // Peripheral path: select picks A or B for level and enable alike
      wire sel_out = ps_q[gi] ? pb_out[gi] : pa_out[gi];
      wire sel_oe = ps_q[gi] ? pb_oe[gi] : pa_oe[gi];
      wire lvl = own_q[gi] ? lv_q[gi] : sel_out;
      wire drv = own_q[gi] ? oe_q[gi] : sel_oe;
      // Open drain: a high level releases the line, so other drivers can pull it low
      wire od_release = od_q[gi] & lvl;
      assign pad_oe[gi] = drv & ~od_release;
      assign pad_out[gi] = lvl & ~od_q[gi];
    end
  endgenerate

  // Bus state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= GLOIC_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // Read data is taken with the request and stands until the next read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= `GLOIC_RST_ZERO;
    end else if (rd_take) begin
      rdata_q <= rd_mux;
    end
  end

  // Owner resets to the controller, so peripherals drive nothing until released
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      own_q <= `GLOIC_RST_OWNER;
    end else begin
      own_q <= own_d;
    end
  end

  // Output enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_q <= `GLOIC_RST_ZERO;
    end else begin
      oe_q <= oe_d;
    end
  end

  // Filter enables
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dg_q <= `GLOIC_RST_ZERO;
    end else begin
      dg_q <= dg_d;
    end
  end

  // Driven levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lv_q <= `GLOIC_RST_ZERO;
    end else begin
      lv_q <= lv_d;
    end
  end

  // Change interrupt mask
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      im_q <= `GLOIC_RST_ZERO;
    end else begin
      im_q <= im_d;
    end
  end

  // Peripheral select, A after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ps_q <= `GLOIC_RST_ZERO;
    end else begin
      ps_q <= ps_d;
    end
  end

  // Open drain off after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      od_q <= `GLOIC_RST_ZERO;
    end else begin
      od_q <= od_d;
    end
  end

  // Direct write mask closed after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_q <= `GLOIC_RST_ZERO;
    end else begin
      sw_q <= sw_d;
    end
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= `GLOIC_RST_ZERO;
    end else begin
      sync1_q <= pad_in;
    end
  end

  // Second stage: the only reader of the first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync2_q <= `GLOIC_RST_ZERO;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  // Filter delay stops with the controller clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_q <= `GLOIC_RST_ZERO;
    end else if (clk_en) begin
      dly_q <= sync2_q;
    end
  end

  // Pin status holds the last sample while the controller clock is stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= `GLOIC_RST_ZERO;
    end else if (clk_en) begin
      pin_q <= in_val;
    end
  end

  // Event bits follow the bus clock so a read clears them with sampling stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_q <= `GLOIC_RST_ZERO;
    end else begin
      ev_q <= ev_d;
    end
  end

endmodule // gloic_top

// File: bench/gloic_chk.sv
// Port assertions for the GPIO line controller
`timescale 1ns/10ps
module gloic_chk
  import gloic_pkg::*;
(
  // Clock, reset, clock gate
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pads and peripherals
  input wire logic [31:0] pad_in,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  input wire logic [31:0] pa_out,
  input wire logic [31:0] pa_oe,
  input wire logic [31:0] pb_out,
  input wire logic [31:0] pb_oe,
  input wire logic [31:0] periph_in,
  input wire logic irq
);
  logic [31:0] own_q, oe_q, lv_q, od_q, sel_q, sw_q, im_q;
  wire we = avs_write && !avs_waitrequest;
  wire rd = avs_read && !avs_waitrequest;
  wire [31:0] bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] w = avs_writedata & bm;
  wire [31:0] m = sw_q & bm;
  wire [31:0] d_oe = own_q & oe_q | ~own_q & (sel_q & pb_oe | ~sel_q & pa_oe);
  wire [31:0] d_lv = own_q & lv_q | ~own_q & (sel_q & pb_out | ~sel_q & pa_out);
  // Shadow of the writable state except the filter enables, updated at the same edge as the design
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      own_q <= '1;
      {oe_q, lv_q, od_q, sel_q, sw_q, im_q} <= '0;
    end else if (we) begin
      case (avs_address)
        8'h00: own_q <= own_q | w;
        8'h04: own_q <= own_q & ~w;
        8'h10: oe_q <= oe_q | w;
        8'h14: oe_q <= oe_q & ~w;
        8'h30: lv_q <= lv_q | w;
        8'h34: lv_q <= lv_q & ~w;
        8'h38: lv_q <= lv_q & ~m | avs_writedata & m;
        8'h40: im_q <= im_q | w;
        8'h44: im_q <= im_q & ~w;
        8'h50: od_q <= od_q | w;
        8'h54: od_q <= od_q & ~w;
        8'h70: sel_q <= sel_q & ~w;
        8'h74: sel_q <= sel_q | w;
        8'ha0: sw_q <= sw_q | w;
        8'ha4: sw_q <= sw_q & ~w;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_drive_en: assert property (pad_oe == (d_oe & ~(od_q & d_lv)))
    else $error("pad enable wrong");
  a_drive_lvl: assert property (pad_out == (~od_q & d_lv))
    else $error("pad level wrong");
  a_periph_raw: assert property (periph_in == pad_in)
    else $error("peripheral input not raw");
  a_irq_masked: assert property (irq |-> im_q != 32'h0)
    else $error("irq with no mask");
  a_irq_clocked: assert property ($rose(irq) && $stable(im_q) |-> $past(clk_en))
    else $error("irq rose with clock stopped");
  a_ev_clear: assert property (rd && avs_address == 8'h4c && !clk_en |=> !irq)
    else $error("event read left irq");
  a_oe_read: assert property (rd && avs_address == 8'h18 |-> avs_readdata == oe_q)
    else $error("enable status wrong");
  a_lvl_read: assert property (rd && avs_address == 8'h38 |-> avs_readdata == lv_q)
    else $error("level status wrong");
  a_mask_read: assert property (rd && avs_address == 8'ha8 |-> avs_readdata == sw_q)
    else $error("write mask status wrong");
  a_od_read: assert property (rd && avs_address == 8'h58 |-> avs_readdata == od_q)
    else $error("open drain status wrong");
  a_im_read: assert property (rd && avs_address == 8'h48 |-> avs_readdata == im_q)
    else $error("irq mask status wrong");
endmodule // gloic_chk

bind gloic_top gloic_chk gloic_chk_inst (.clk, .arst_n, .clk_en, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pad_in, .pad_out, .pad_oe,
  .pa_out, .pa_oe, .pb_out, .pb_oe, .periph_in, .irq);

// File: bench/gloic_pins.sv
// Pad model: far drivers and pull-ups on the 32 lines
`timescale 1ns/10ps
module gloic_pins (
  // Controller side
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe,
  // Far drivers
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_oe,
  // Resolved level
  output logic [31:0] pad_in
);
  // A released line floats high through its pull-up, never keeps the old level
  assign pad_in = pad_oe & pad_out | ~pad_oe & (ext_oe & ext_val | ~ext_oe);
endmodule // gloic_pins

// File: bench/gloic_top_tb.sv
// Self-checking bench for the GPIO line controller
`timescale 1ns/10ps
module gloic_top_tb;
  import gloic_pkg::*;
  logic clk, arst_n, clk_en, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  gloic_word_t avs_writedata, avs_readdata, ext_val, ext_oe, pa_out, pa_oe, pb_out, pb_oe, rv;
  logic [31:0] pad_in, pad_out, pad_oe, periph_in;
  int mismatches, checked, cyc;
  gloic_top gloic_top_inst (.clk, .arst_n, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pad_in, .pad_out, .pad_oe, .pa_out, .pa_oe,
    .pb_out, .pb_oe, .periph_in, .irq);
  gloic_pins gloic_pins_inst (.pad_out, .pad_oe, .ext_val, .ext_oe, .pad_in);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end
  task test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input gloic_word_t got, input gloic_word_t exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus access; waitrequest is looked at on the rising edge, where the answer is taken
  task acc(input logic wr, input logic [7:0] a, input gloic_word_t d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task rdc(input logic [7:0] a, input gloic_word_t e);
    acc(1'b0, a, '0);
    chk(rv, e);
  endtask
  task t_reset;
    rdc(8'h08, 32'hffff_ffff);
    rdc(8'h58, '0);
    rdc(8'ha8, '0);
    rdc(8'h0c, '0);
    chk(pad_oe, '0);
  endtask
  task t_inputs;
    acc(1'b0, 8'h4c, '0);
    acc(1'b1, 8'h40, 32'h100);
    rdc(8'h48, 32'h100);
    acc(1'b1, 8'h20, 32'h100);
    rdc(8'h28, 32'h100);
    ext_oe <= 32'h100;
    repeat (5) @(posedge clk);
    chk(32'(irq), 32'h1);
    clk_en <= 1'b0;
    rdc(8'h3c, 32'hffff_feff);
    rdc(8'h4c, 32'h100);
    chk(32'(irq), 32'h0);
    ext_oe <= '0;
    repeat (5) @(posedge clk);
    rdc(8'h3c, 32'hffff_feff);
    rdc(8'h4c, '0);
    clk_en <= 1'b1;
    repeat (5) @(posedge clk);
    chk(32'(irq), 32'h1);
    acc(1'b1, 8'h44, 32'h100);
    chk(32'(irq), 32'h0);
  endtask
  task t_filter;
    acc(1'b1, 8'h40, 32'h100);
    acc(1'b0, 8'h4c, '0);
    ext_oe <= 32'h100;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    acc(1'b1, 8'h44, 32'h100);
    acc(1'b1, 8'h40, 32'h200);
    acc(1'b0, 8'h4c, '0);
    ext_oe <= 32'h300;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    ext_oe <= 32'h200;
    @(posedge clk);
    ext_oe <= 32'h300;
    repeat (6) @(posedge clk);
    rdc(8'h4c, 32'h300);
  endtask
  task t_outputs;
    acc(1'b1, 8'h10, 32'hf);
    acc(1'b1, 8'h30, 32'h5);
    acc(1'b1, 8'h34, 32'h1);
    chk(pad_out, 32'h4);
    chk(pad_oe, 32'hf);
    acc(1'b1, 8'ha0, 32'h3);
    acc(1'b1, 8'h38, '1);
    rdc(8'h38, 32'h7);
    acc(1'b1, 8'ha4, 32'h1);
    rdc(8'ha8, 32'h2);
    acc(1'b1, 8'h50, 32'h1);
    chk(pad_oe, 32'he);
    chk(pad_out, 32'h6);
  endtask
  task t_periph;
    acc(1'b1, 8'h04, 32'h000f_0000);
    acc(1'b1, 8'h10, 32'h000f_0000);
    rdc(8'h18, 32'h000f_000f);
    rdc(8'h08, 32'hfff0_ffff);
    chk(pad_oe, 32'h000f_000e);
    chk(pad_out, 32'h0005_0006);
    acc(1'b1, 8'h74, 32'h000f_0000);
    rdc(8'h78, 32'h000f_0000);
    acc(1'b1, 8'h30, 32'h0003_0000);
    rdc(8'h38, 32'h0003_0007);
    chk(pad_out, 32'h000a_0006);
    chk(periph_in, pad_in);
  endtask
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    ext_val = '0;
    ext_oe = '0;
    pa_out = 32'h5555_5555;
    pa_oe = '1;
    pb_out = 32'haaaa_aaaa;
    pb_oe = '1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_inputs();
    t_filter();
    t_outputs();
    t_periph();
    test_done();
  end
endmodule // gloic_top_tb
